// ===== hdl/serial_cmd_pkg.sv
// Shared constants for the serial command port, both link ends.
// Assumes a single pclk domain per end; link pins are asynchronous.
// Function
// RULE1 - Command word: address byte, then data byte
// RULE2 - Input bit reappears at output 15.5 clocks later
// RULE3 - Host gives sixteen clocks per chained device
// RULE4 - Host sends no_operation_command to untouched chained devices
// RULE5 - Shift on rising clock only while selected
// RULE6 - Select rise latches word and executes it
// RULE7 - Host idles clock low, MSB first framing
// RULE8 - Top bit: zero write, one read
// RULE9 - Extra bits: only last sixteen kept
// RULE10 - Read address in bits 14..8, data ignored
// RULE11 - Read loads addressed register into low byte
// RULE12 - Host reads answer during following command
// RULE13 - Reset clears controls, minimum current, shutdown
// RULE14 - Per-segment select chooses nibble or global current
// RULE15 - Seven-bit mask enables monitored ports
// RULE16 - Change reported high on interrupt port
// RULE17 - Host configures interrupt port as output
// RULE18 - Arm write snapshots monitored ports every time
// RULE19 - Arming lowers interrupt; stays until disarm/change
// RULE20 - Any difference latches interrupt high
// RULE21 - Mask register access or arming write clears interrupt
// RULE22 - Detection one-shot until rearmed
// RULE23 - Serial output always actively driven
// RULE24 - Unimplemented addresses accepted without effect

package serial_cmd_pkg;

  localparam int WORD_W    = 16;
  localparam int ADDR_MSB  = 14;
  localparam int ADDR_LSB  = 8;
  localparam int RW_BIT    = 15;
  localparam int MON_W     = 7;
  localparam int NPORT     = 28;
  localparam int NCUR      = 14;

  localparam logic [6:0] ADDR_NOOP   = 7'h00;
  localparam logic [6:0] ADDR_GLOBAL = 7'h02;
  localparam logic [6:0] ADDR_CONFIG = 7'h04;
  localparam logic [6:0] ADDR_MASK   = 7'h06;
  localparam logic [6:0] ADDR_CUR_LO = 7'h12;
  localparam logic [6:0] ADDR_CUR_HI = 7'h1F;

  // Configuration register fields
  localparam int CFG_RUN_BIT = 0;
  localparam int CFG_SEG_BIT = 6;
  localparam int CFG_ARM_BIT = 7;

  localparam logic [7:0] RST_GLOBAL = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_CUR    = 8'h00;
  localparam logic [6:0] RST_MASK   = 7'h00;

  // Host controller APB map
  localparam logic [11:0] HOFS_CMD    = 12'h000;
  localparam logic [11:0] HOFS_STATUS = 12'h004;
  localparam logic [11:0] HOFS_RX     = 12'h008;
  localparam int CMD_HOLD_BIT = 16;
  localparam int HALF_DIV_DEF = 8;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_LOW  = 2'b01,
    H_HIGH = 2'b11,
    H_DONE = 2'b10
  } host_state_e;

endpackage

// ===== hdl/serial_link_if.sv
// Four-wire serial link between host controller and command port.
// Assumes both ends are joined by the bench; no clocking block.
`timescale 1ns/100ps
`default_nettype none

interface serial_link_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo;

  modport device (
    input  sclk,
    input  cs_n,
    input  sdi,
    output sdo
  );

  modport host (
    output sclk,
    output cs_n,
    output sdi,
    input  sdo
  );
endinterface

`default_nettype wire

// ===== hdl/pin_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to pclk.
`timescale 1ns/100ps
`default_nettype none

module pin_sync3 #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } sync_s;

  sync_s st_q;
  sync_s st_d;

  // First stage feeds only the second stage
  always_comb
  begin
    st_d     = st_q;
    st_d.s1  = pin;
    st_d.s2  = st_q.s1;
    st_d.s3  = st_q.s2;
    for (int i = 0; i < W; i++)
    begin
      if (st_q.s2[i] == st_q.s3[i])
        st_d.out[i] = st_q.s2[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '{s1: RST, s2: RST, s3: RST, out: RST};
    else if (clk_en)
      st_q <= st_d;
  end

  assign level = st_q.out;

endmodule

`default_nettype wire

// ===== hdl/serial_cmd_host.sv
// Host end: APB-programmed serial master making the link clock.
// Assumes an APB master on pclk; sdo arrives asynchronously.
`timescale 1ns/100ps
`default_nettype none

module serial_cmd_host #(
  parameter int HALF_DIV = serial_cmd_pkg::HALF_DIV_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  serial_link_if.host      link
);

  typedef struct packed {
    serial_cmd_pkg::host_state_e st;
    logic [15:0] cnt;
    logic [4:0]  bits;
    logic [15:0] tx;
    logic [15:0] rx;
    logic        hold;
    logic        sclk;
    logic        cs_n;
    logic        sdi;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } host_s;

  host_s h_q;
  host_s h_d;
  logic  sdo_s;
  logic  tick;
  logic  acc;

  pin_sync3 #(.W(1), .RST(1'b0)) u_sdo_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .pin     (link.sdo),
    .level   (sdo_s)
  );

  assign tick = (h_q.cnt == 16'(HALF_DIV - 1));
  assign acc  = psel & penable & ~h_q.pready;

  always_comb
  begin
    h_d         = h_q;
    h_d.pready  = 1'b0;
    h_d.pslverr = 1'b0;
    h_d.cnt     = tick ? 16'h0000 : h_q.cnt + 16'h0001;
    // Answer one cycle into the access phase
    if (acc)
    begin
      h_d.pready = 1'b1;
      h_d.prdata = 32'h0000_0000;
      if (paddr == serial_cmd_pkg::HOFS_CMD)
      begin
        if (pwrite && h_q.st == serial_cmd_pkg::H_IDLE)
        begin
          h_d.tx   = pwdata[15:0];
          h_d.hold = pwdata[serial_cmd_pkg::CMD_HOLD_BIT];
          h_d.bits = 5'h00;
          h_d.cs_n = 1'b0;                           // [RULE7]
          h_d.sdi  = pwdata[15];                     // [RULE1]
          h_d.cnt  = 16'h0000;
          h_d.st   = serial_cmd_pkg::H_LOW;
        end
        else if (pwrite)
          h_d.pslverr = 1'b1;
      end
      else if (paddr == serial_cmd_pkg::HOFS_STATUS)
        h_d.prdata = {30'h0, ~h_q.cs_n,
                      h_q.st != serial_cmd_pkg::H_IDLE};
      else if (paddr == serial_cmd_pkg::HOFS_RX)
        h_d.prdata = {16'h0000, h_q.rx};             // [RULE12]
      else
        h_d.pslverr = 1'b1;
    end
    case (h_q.st)
      // Frame start is set by the bus decode above
      serial_cmd_pkg::H_IDLE:
        h_d.sclk = 1'b0;                             // [RULE7]
      serial_cmd_pkg::H_LOW:
        if (tick)
        begin
          h_d.sclk = 1'b1;
          h_d.st   = serial_cmd_pkg::H_HIGH;
        end
      serial_cmd_pkg::H_HIGH:
        if (tick)
        begin
          h_d.sclk = 1'b0;
          // Sync lag: synced sdo at the fall is the bit held at the rise;
          // needs a half period of five clocks or more
          h_d.rx   = {h_q.rx[14:0], sdo_s};          // [RULE12]
          h_d.bits = h_q.bits + 5'h01;
          h_d.tx   = {h_q.tx[14:0], 1'b0};
          h_d.sdi  = h_q.tx[14];                     // [RULE7]
          // Held select chains words for n devices
          if (h_q.bits == 5'h0F)
            h_d.st = h_q.hold ? serial_cmd_pkg::H_IDLE  // [RULE3]
                              : serial_cmd_pkg::H_DONE;
          else
            h_d.st = serial_cmd_pkg::H_LOW;
        end
      serial_cmd_pkg::H_DONE:
        if (tick)
        begin
          h_d.cs_n = 1'b1;                           // [RULE7]
          h_d.st   = serial_cmd_pkg::H_IDLE;
        end
      default:
        h_d.st = serial_cmd_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      h_q <= '{st: serial_cmd_pkg::H_IDLE, cs_n: 1'b1, default: '0};
    else if (clk_en)
      h_q <= h_d;
  end

  assign prdata    = h_q.prdata;
  assign pready    = h_q.pready;
  assign pslverr   = h_q.pslverr;
  assign link.sclk = h_q.sclk;
  assign link.cs_n = h_q.cs_n;
  assign link.sdi  = h_q.sdi;

endmodule

`default_nettype wire

// ===== hdl/serial_cmd_device.sv
// Device end: serial command port, current select, change detect.
// Assumes link pins and monitored ports are asynchronous to pclk.
//
// Implementation choice: link pins oversampled on pclk, no APB port.
`timescale 1ns/100ps
`default_nettype none

module serial_cmd_device (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          clk_en,
  input  wire logic [6:0]    monitored_ports,
  output logic               interrupt_port,
  output logic               shutdown,
  output logic [111:0]       drive_level,
  serial_link_if.device      link
);

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic [15:0]      sr;
    logic [15:0]      latch;
    logic             sdo;
    logic             sclk_p;
    logic             cs_p;
    logic [7:0]       glob;
    logic [7:0]       cfg;
    logic [6:0]       mask;
    logic [13:0][7:0] cur;
    logic [6:0]       snap;
    logic             armed;
    logic             intr;
    logic [111:0]     drive;
    logic             shut;
  } dev_s;

  dev_s        d_q;
  dev_s        d_d;
  logic [9:0]  syn;
  logic        sclk_s;
  logic        cs_s;
  logic        sdi_s;
  logic [6:0]  mon_s;
  logic        rise;
  logic        fall;
  logic        cs_rise;
  logic [15:0] cmd;
  logic [6:0]  addr;
  logic [15:0] sr_n;
  logic        change;
  logic [111:0] drive_n;

  // ****************************************************
  // Input synchronisers
  // ****************************************************
  pin_sync3 #(.W(10), .RST(10'h002)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .pin     ({monitored_ports, link.sdi, link.cs_n, link.sclk}),
    .level   (syn)
  );

  assign sclk_s = syn[0];
  assign cs_s   = syn[1];
  assign sdi_s  = syn[2];
  assign mon_s  = syn[9:3];

  // Clock edges count only while selected
  assign rise    = sclk_s & ~d_q.sclk_p & ~cs_s;        // [RULE5]
  assign fall    = ~sclk_s & d_q.sclk_p & ~cs_s;
  assign cs_rise = cs_s & ~d_q.cs_p;

  // ****************************************************
  // Register decode
  // ****************************************************
  function automatic logic is_cur(input logic [6:0] a);
    is_cur = (a >= serial_cmd_pkg::ADDR_CUR_LO) &&
             (a <= serial_cmd_pkg::ADDR_CUR_HI);
  endfunction

  function automatic logic [3:0] cur_idx(input logic [6:0] a);
    logic [6:0] t;
    t       = a - serial_cmd_pkg::ADDR_CUR_LO;
    cur_idx = t[3:0];
  endfunction

  function automatic logic [7:0] rd_mux(input logic [6:0] a,
                                        input dev_s     s);
    if (a == serial_cmd_pkg::ADDR_GLOBAL)
      rd_mux = s.glob;
    else if (a == serial_cmd_pkg::ADDR_CONFIG)
      rd_mux = s.cfg;
    else if (a == serial_cmd_pkg::ADDR_MASK)
      rd_mux = {1'b0, s.mask};
    else if (is_cur(a))
      rd_mux = s.cur[cur_idx(a)];
    else
      rd_mux = 8'h00;
  endfunction

  // ****************************************************
  // Drive level per physical port
  // ****************************************************
  // Each port takes its nibble or the shared global value
  generate
    for (genvar p = 0; p < serial_cmd_pkg::NPORT; p++)
    begin : g_drive
      assign drive_n[p*4 +: 4] =
        d_q.cfg[serial_cmd_pkg::CFG_SEG_BIT]
          ? d_q.cur[p/2][(p%2)*4 +: 4]                  // [RULE14]
          : d_q.glob[3:0];                              // [RULE14]
    end
  endgenerate

  // Any masked difference from the snapshot while armed that lasts two pclk cycles or more
  assign change = d_q.armed &&
                  |((mon_s ^ d_q.snap) & d_q.mask);     // [RULE15]

  // Command seen at select rise is the last sixteen bits
  assign cmd  = d_q.sr;                                 // [RULE9]
  assign addr = cmd[serial_cmd_pkg::ADDR_MSB:serial_cmd_pkg::ADDR_LSB];
  assign sr_n = {d_q.sr[14:0], sdi_s};

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb
  begin
    d_d        = d_q;
    d_d.sclk_p = sclk_s;
    d_d.cs_p   = cs_s;
    d_d.drive  = drive_n;
    d_d.shut   = ~d_q.cfg[serial_cmd_pkg::CFG_RUN_BIT];  // [RULE13]

    if (rise)
      d_d.sr = sr_n;                                    // [RULE5]

    // Bit shifted in 15 rises ago leaves on this fall
    if (fall)
      d_d.sdo = d_q.sr[15];                             // [RULE2]

    // Interrupt clear by mask access, set has priority below
    if (cs_rise && addr == serial_cmd_pkg::ADDR_MASK)
      d_d.intr = 1'b0;                                  // [RULE21]

    if (cs_rise)
    begin
      d_d.latch = cmd;                                  // [RULE6]
      if (!cmd[serial_cmd_pkg::RW_BIT])                 // [RULE8]
      begin
        if (addr == serial_cmd_pkg::ADDR_GLOBAL)
          d_d.glob = cmd[7:0];                          // [RULE1]
        else if (addr == serial_cmd_pkg::ADDR_CONFIG)
        begin
          d_d.cfg = cmd[7:0];
          if (cmd[serial_cmd_pkg::CFG_ARM_BIT])
          begin
            d_d.snap  = mon_s;                          // [RULE18]
            d_d.armed = 1'b1;                           // [RULE19]
            d_d.intr  = 1'b0;                           // [RULE19]
          end
          else
            d_d.armed = 1'b0;                           // [RULE19]
        end
        else if (addr == serial_cmd_pkg::ADDR_MASK)
          d_d.mask = cmd[6:0];
        else if (is_cur(addr))
          d_d.cur[cur_idx(addr)] = cmd[7:0];
        // Other addresses are latched and do nothing [RULE24]
      end
      else
      begin
        // Low byte of the request is discarded
        d_d.sr = {cmd[15:8], rd_mux(addr, d_q)};        // [RULE10]
        // [RULE11]
      end
      // Show the new top bit while idle
      d_d.sdo = d_d.sr[15];                             // [RULE23]
    end

    // Latch on first change and disarm; clearing later
    // leaves detection off until the next arming write
    if (change)
    begin
      d_d.intr  = 1'b1;                                 // [RULE20]
      d_d.armed = 1'b0;                                 // [RULE22]
    end
  end

  // ****************************************************
  // Registers
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Controls cleared, minimum current, shut down
      d_q       <= '0;                                  // [RULE13]
      d_q.cs_p  <= 1'b1;
      d_q.shut  <= 1'b1;                                // [RULE13]
      d_q.glob  <= serial_cmd_pkg::RST_GLOBAL;          // [RULE13]
      d_q.cfg   <= serial_cmd_pkg::RST_CONFIG;          // [RULE13]
      d_q.mask  <= serial_cmd_pkg::RST_MASK;
      d_q.cur   <= {serial_cmd_pkg::NCUR{serial_cmd_pkg::RST_CUR}};
    end
    else if (clk_en)
      d_q <= d_d;
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  // Serial output has no high-impedance state
  assign link.sdo       = d_q.sdo;                      // [RULE23]
  assign interrupt_port = d_q.intr;                     // [RULE16]
  assign shutdown       = d_q.shut;
  assign drive_level    = d_q.drive;

endmodule

`default_nettype wire

// ===== verification/serial_cmd_props.sv
// Link checker: framing, phase lengths and echo on the shared wires.
// Assumes the wires are sampled on pclk of both ends.
`timescale 1ns/100ps
`default_nettype none

module serial_cmd_props #(
  parameter int HALF_DIV = serial_cmd_pkg::HALF_DIV_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo
);
  // ****
  // Helper state
  // ****
  logic [1:0]  prev_q;
  logic [15:0] run_q;
  logic [15:0] echo_q;
  logic [7:0]  bits_q;

  // Run length since last change of clock or select
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_q <= 2'h1;
      run_q  <= 16'h0;
      echo_q <= 16'h0;
      bits_q <= 8'h0;
    end
    else
    begin
      prev_q <= {sclk, cs_n};
      run_q  <= ({sclk, cs_n} != prev_q) ? 16'h1 : run_q + 16'h1;
      if (cs_n)
        bits_q <= 8'h0;
      else if (sclk && !prev_q[1])
      begin
        bits_q <= bits_q + 8'h1;
        echo_q <= {echo_q[14:0], sdi};
      end
    end
  end

  // ****
  // Properties
  // ****
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  idle_clock_low_a: assert property (cs_n |-> !sclk)
    else $error("link clock high while deselected");
  high_phase_a: assert property ($fell(sclk) |-> run_q == HALF_DIV)
    else $error("clock high phase length wrong");
  low_phase_a: assert property ($rose(sclk) |-> run_q >= HALF_DIV)
    else $error("clock low phase too short");
  data_hold_a: assert property (sclk && $past(sclk) |-> $stable(sdi))
    else $error("data in moved while clock high");
  out_steady_a: assert property (sclk |-> $stable(sdo))
    else $error("data out moved while clock high");
  echo_delay_a: assert property ($rose(sclk) && bits_q >= 8'h10
    |-> sdo == echo_q[15])
    else $error("data out is not the bit sixteen clocks back");
  select_rise_a: assert property ($rose(cs_n) |-> run_q >= HALF_DIV)
    else $error("select rose too soon after last clock");
  whole_words_a: assert property ($rose(cs_n)
    |-> bits_q[3:0] == 4'h0 && bits_q != 8'h0)
    else $error("frame is not whole sixteen bit words");

  cover property ($rose(cs_n) && bits_q == 8'h20);
  cover property ($rose(sclk) && bits_q >= 8'h10);
  cover property ($fell(cs_n));
endmodule

`default_nettype wire

// ===== verification/serial_command_port_with_change_detect_bench.sv
// Bench: APB drives the host end, which talks to the device end.
// Assumes one pclk for both ends; monitored ports come from here.
`timescale 1ns/100ps
`default_nettype none

module serial_command_port_with_change_detect_bench;
  localparam int HD = 8;
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [6:0]   mon;
  logic         irq;
  logic         shutdown;
  logic [111:0] drive_level;
  logic [31:0]  rd;
  logic         err;
  logic [7:0]   v;
  logic [7:0]   glob;
  logic [7:0]   cur [14];
  int           bad_count;
  int           comparisons;

  serial_link_if link ();
  serial_cmd_host #(.HALF_DIV(HD)) serial_cmd_host_inst (.pclk(pclk),
    .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  serial_cmd_device serial_cmd_device_inst (.pclk(pclk), .presetn(presetn),
    .clk_en(1'b1), .monitored_ports(mon), .interrupt_port(irq),
    .shutdown(shutdown), .drive_level(drive_level), .link(link));
  serial_cmd_props #(.HALF_DIV(HD)) serial_cmd_props_inst (.pclk(pclk),
    .presetn(presetn), .sclk(link.sclk), .cs_n(link.cs_n),
    .sdi(link.sdi), .sdo(link.sdo));

  always #5 pclk = ~pclk;

  // ****
  // Tasks
  // ****
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [111:0] seen, input logic [111:0] want,
                       input string what);
    comparisons++;
    if (seen !== want)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      bad_count++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Waits out the frame, then the device's execute latency
  task automatic send(input logic [15:0] w, input logic hold);
    int n;
    apb(1'b1, serial_cmd_pkg::HOFS_CMD, {15'h0, hold, w});
    n = 0;
    do
    begin
      apb(1'b0, serial_cmd_pkg::HOFS_STATUS, 32'h0);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 200);
    if (n >= 200)
    begin
      bad_count++;
      final_report();
    end
    repeat (8) @(posedge pclk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    send({1'b0, a, d}, 1'b0);
  endtask

  // Junk low byte on purpose: the device must drop it
  task automatic rdreg(input logic [6:0] a, output logic [7:0] d);
    send({1'b1, a, 8'($urandom)}, 1'b0);
    send(16'h0000, 1'b0);
    apb(1'b0, serial_cmd_pkg::HOFS_RX, 32'h0);
    d = rd[7:0];
  endtask

  // Pulse long enough to pass the input filter
  task automatic poke(input int k);
    mon[k] <= ~mon[k];
    repeat (6) @(posedge pclk);
    mon[k] <= ~mon[k];
    repeat (8) @(posedge pclk);
  endtask

  function automatic logic [111:0] levels(input logic seg);
    logic [111:0] x;
    for (int p = 0; p < 28; p++)
      x[p*4 +: 4] = seg ? cur[p/2][(p%2)*4 +: 4] : glob[3:0];
    return x;
  endfunction

  // ****
  // Sequence
  // ****
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    mon = 7'h0;
    bad_count = 0;
    comparisons = 0;
    rd = $urandom(32'h51F0);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(shutdown, 1'b1, "shutdown");
    check(irq, 1'b0, "interrupt");
    check(drive_level, 112'h0, "drive level");
    check(link.sdo, 1'b0, "data out");
    rdreg(serial_cmd_pkg::ADDR_CONFIG, v);
    check(v, serial_cmd_pkg::RST_CONFIG, "config");
    rdreg(7'h20, v);
    check(v, 8'h00, "unmapped read");
    apb(1'b0, 12'hFFC, 32'h0);
    check(err, 1'b1, "apb error");
    $display("reset test done");

    glob = 8'($urandom);
    wr(serial_cmd_pkg::ADDR_GLOBAL, glob);
    wr(serial_cmd_pkg::ADDR_CONFIG, 8'h01);
    rdreg(serial_cmd_pkg::ADDR_GLOBAL, v);
    check(v, glob, "global");
    check(shutdown, 1'b0, "shutdown");
    check(drive_level, levels(1'b0), "drive level");
    for (int i = 0; i < 14; i++)
    begin
      cur[i] = 8'($urandom);
      wr(7'(serial_cmd_pkg::ADDR_CUR_LO + 7'(i)), cur[i]);
    end
    wr(serial_cmd_pkg::ADDR_CONFIG, 8'h41);
    wr(7'h25, 8'hFF);
    check(drive_level, levels(1'b1), "drive level");
    rdreg(serial_cmd_pkg::ADDR_CUR_HI, v);
    check(v, cur[13], "current");
    glob = 8'($urandom);
    send({1'b0, serial_cmd_pkg::ADDR_GLOBAL, ~glob}, 1'b1);
    send({1'b0, serial_cmd_pkg::ADDR_GLOBAL, glob}, 1'b0);
    wr(serial_cmd_pkg::ADDR_CONFIG, 8'h01);
    check(drive_level, levels(1'b0), "drive level");
    $display("register test done");

    wr(7'h0F, 8'h40);
    wr(serial_cmd_pkg::ADDR_MASK, 8'h7F);
    mon <= 7'($urandom);
    repeat (8) @(posedge pclk);
    wr(serial_cmd_pkg::ADDR_CONFIG, 8'h81);
    check(irq, 1'b0, "interrupt");
    poke(3);
    check(irq, 1'b1, "interrupt");
    wr(serial_cmd_pkg::ADDR_GLOBAL, glob);
    check(irq, 1'b1, "interrupt");
    rdreg(serial_cmd_pkg::ADDR_MASK, v);
    check(v, 8'h7F, "mask");
    check(irq, 1'b0, "interrupt");
    poke(5);
    check(irq, 1'b0, "interrupt");
    wr(serial_cmd_pkg::ADDR_MASK, 8'h01);
    wr(serial_cmd_pkg::ADDR_CONFIG, 8'h81);
    poke(4);
    check(irq, 1'b0, "interrupt");
    poke(0);
    check(irq, 1'b1, "interrupt");
    wr(serial_cmd_pkg::ADDR_CONFIG, 8'h81);
    check(irq, 1'b0, "interrupt");
    wr(serial_cmd_pkg::ADDR_CONFIG, 8'h01);
    poke(0);
    check(irq, 1'b0, "interrupt");
    $display("detect test done");
    final_report();
  end
endmodule

`default_nettype wire
